// >>> src/irq_mask_pkg.sv
`default_nettype none
package irq_mask_pkg;
  // Register data width and port count
  localparam int unsigned REG_W = 16;
  localparam int unsigned NUM_PORTS = 12;
  localparam int unsigned TEMP_BITS = 3;

  // Register indices on the register access port
  localparam logic [2:0] IDX_SOURCE_MASK = 3'h0;
  localparam logic [2:0] IDX_MODE_LOW = 3'h1;
  localparam logic [2:0] IDX_MODE_HIGH = 3'h2;
  localparam logic [2:0] IDX_STATUS_LOW = 3'h3;
  localparam logic [2:0] IDX_STATUS_HIGH = 3'h4;

  // Field positions inside the source mask register
  localparam int unsigned POS_SWEEP_END = 0;
  localparam int unsigned POS_CONV_READY = 1;
  localparam int unsigned POS_CONV_MISSED = 2;
  localparam int unsigned POS_EVT_READY = 3;
  localparam int unsigned POS_EVT_MISSED = 4;
  localparam int unsigned POS_OVERCURRENT = 5;
  localparam int unsigned POS_CORE_TEMP = 6;
  localparam int unsigned POS_REMOTE_A = 9;
  localparam int unsigned POS_REMOTE_B = 12;
  localparam int unsigned POS_HV_SUPPLY = 15;

  // Mode field positions: ports 0-5 in the low register from bit 4,
  // ports 6-10 in the high register from bit 6, port 11 at bit 0
  localparam int unsigned MODE_LOW_BASE = 4;
  localparam int unsigned MODE_HIGH_BASE = 6;
  localparam int unsigned MODE_P11_BASE = 0;
  localparam int unsigned LOW_PORTS = 6;

  // Writable bits; reserved bits read as zero
  localparam logic [15:0] MODE_LOW_WMASK = 16'hFFF0;
  localparam logic [15:0] MODE_HIGH_WMASK = 16'hFFC3;

  // Values after reset
  localparam logic [15:0] SOURCE_MASK_RESET = 16'hFFFF;
  localparam logic [15:0] MODE_RESET = 16'h0000;

  // Edge mode codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Continuous-sweep pulse length
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SWEEP_PULSE_NS = 100;
  localparam int unsigned SWEEP_PULSE_CYCLES =
    (SWEEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W = 4;

  // Clear sequence states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_ARMED = 2'b10
  } seq_state_type;
endpackage
`default_nettype wire

// >>> src/edge_if.sv
`default_nettype none
interface edge_if;
  logic [11:0] pin_level;
  logic [23:0] mode;
  logic [11:0] evt;
  modport det (input pin_level, input mode, output evt);
  modport ctl (output pin_level, output mode, input evt);
endinterface
`default_nettype wire

// >>> src/port_edge_detect.sv
`default_nettype none
module port_edge_detect (
  input wire logic clk_i,
  input wire logic rst_n_i,
  edge_if.det bus
);
  logic [11:0] sync1_r;
  logic [11:0] sync2_r;
  logic [11:0] sync3_r;
  logic [11:0] stable_r;
  logic [11:0] evt_r;

  // Three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= 12'h000;
      sync2_r <= 12'h000;
      sync3_r <= 12'h000;
    end else begin
      sync1_r <= bus.pin_level;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // A level change counts only once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_r <= 12'h000;
    end else begin
      for (int i = 0; i < 12; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          stable_r[i] <= sync3_r[i];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_r <= 12'h000;
    end else begin
      for (int i = 0; i < 12; i++) begin
        logic rise;
        logic fall;
        rise = 1'b0;
        fall = 1'b0;
        rise = (sync2_r[i] == sync3_r[i]) && sync3_r[i] && !stable_r[i];
        fall = (sync2_r[i] == sync3_r[i]) && !sync3_r[i] && stable_r[i];
        unique case (bus.mode[2*i +: 2])
          irq_mask_pkg::EDGE_NONE: evt_r[i] <= 1'b0;
          irq_mask_pkg::EDGE_RISE: evt_r[i] <= rise;
          irq_mask_pkg::EDGE_FALL: evt_r[i] <= fall;
          irq_mask_pkg::EDGE_BOTH: evt_r[i] <= rise | fall;
        endcase
      end
    end
  end

  assign bus.evt = evt_r;
endmodule
`default_nettype wire

// >>> src/status_clear_seq.sv
`default_nettype none
module status_clear_seq (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic int_reg_read_i,
  input wire logic status_low_read_i,
  input wire logic status_high_read_i,
  output logic clear_o
);
  irq_mask_pkg::seq_state_type state_r;
  logic got_low_r;
  logic got_high_r;
  logic clear_r;
  logic low_seen;
  logic high_seen;

  assign low_seen = got_low_r | status_low_read_i;
  assign high_seen = got_high_r | status_high_read_i;

  // Interrupt register read arms; both status reads then clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= irq_mask_pkg::SEQ_IDLE;
      got_low_r <= 1'b0;
      got_high_r <= 1'b0;
      clear_r <= 1'b0;
    end else begin
      clear_r <= 1'b0;
      unique case (state_r)
        irq_mask_pkg::SEQ_IDLE: begin
          got_low_r <= 1'b0;
          got_high_r <= 1'b0;
          if (int_reg_read_i) begin
            state_r <= irq_mask_pkg::SEQ_ARMED;
          end
        end
        irq_mask_pkg::SEQ_ARMED: begin
          if (int_reg_read_i) begin
            // A fresh interrupt read restarts the sequence
            got_low_r <= 1'b0;
            got_high_r <= 1'b0;
          end else if (low_seen && high_seen) begin
            clear_r <= 1'b1;
            state_r <= irq_mask_pkg::SEQ_IDLE;
          end else begin
            got_low_r <= low_seen;
            got_high_r <= high_seen;
          end
        end
        default: begin
          state_r <= irq_mask_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  assign clear_o = clear_r;
endmodule
`default_nettype wire

// >>> src/irq_mask_top.sv
`default_nettype none
module irq_mask_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Register access from the serial interface
  input wire logic [2:0] REG_SEL_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic INT_REG_READ_I,
  output logic [15:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // Interrupt sources from the rest of the device
  input wire logic SWEEP_END_FLAG_I,
  input wire logic CONVERSION_READY_FLAG_I,
  input wire logic CONVERSION_MISSED_FLAG_I,
  input wire logic DRIVER_OVERCURRENT_FLAG_I,
  input wire logic [2:0] CORE_TEMP_ALARM_BITS_I,
  input wire logic [2:0] REMOTE_TEMP_A_ALARM_BITS_I,
  input wire logic [2:0] REMOTE_TEMP_B_ALARM_BITS_I,
  input wire logic HV_SUPPLY_ALARM_FLAG_I,
  // Sweep timing from the converter sequencer
  input wire logic CONT_SWEEP_MODE_I,
  input wire logic SWEEP_DONE_I,
  // Input port pins
  input wire logic [11:0] PORT_LEVEL_I,
  // Event flags towards the interrupt register
  output logic INPUT_EVENT_READY_FLAG_O,
  output logic INPUT_EVENT_MISSED_FLAG_O,
  // Interrupt line
  output logic INT_N_O
);
  logic rst_meta_r;
  logic rst_n_r;
  logic [15:0] source_mask_r;
  logic [15:0] mode_low_r;
  logic [15:0] mode_high_r;
  logic [11:0] port_event_status_r;
  logic [11:0] port_event_status_nxt;
  logic evt_missed_r;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic [3:0] pulse_cnt_r;
  logic int_n_r;
  logic status_clear;
  logic [11:0] port_evt;
  logic [23:0] port_edge_mode;
  logic [15:0] mask_wr_val;
  logic [15:0] pending;
  logic rd_status_low;
  logic rd_status_high;
  logic wr_mask;
  logic wr_mode_low;
  logic wr_mode_high;

  edge_if edge_bus ();

  // Reset is released through two flip-flops
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Gathers a port's 2-bit mode from the two mode registers
  function automatic logic [1:0] mode_of(input int unsigned port,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
    int unsigned pos;
    pos = 0;
    if (port < irq_mask_pkg::LOW_PORTS) begin
      pos = irq_mask_pkg::MODE_LOW_BASE + 2 * port;
      return lo[pos +: 2];
    end else if (port < irq_mask_pkg::NUM_PORTS - 1) begin
      pos = irq_mask_pkg::MODE_HIGH_BASE
            + 2 * (port - irq_mask_pkg::LOW_PORTS);
      return hi[pos +: 2];
    end
    return hi[irq_mask_pkg::MODE_P11_BASE +: 2];
  endfunction

  // True when a strobe addresses the given register index
  function automatic logic reg_hit(input logic strobe,
                                   input logic [2:0] sel,
                                   input logic [2:0] idx);
    return strobe && (sel == idx);
  endfunction

  always_comb begin
    for (int i = 0; i < 12; i++) begin
      port_edge_mode[2*i +: 2] = mode_of(i, mode_low_r, mode_high_r);
    end
  end

  assign edge_bus.pin_level = PORT_LEVEL_I;
  assign edge_bus.mode = port_edge_mode;
  assign port_evt = edge_bus.evt;

  port_edge_detect u_edge (
    .clk_i (CLK_I),
    .rst_n_i (rst_n_r),
    .bus (edge_bus.det)
  );

  // Register strobe decode
  assign rd_status_low = reg_hit(REG_RD_I, REG_SEL_I,
                                 irq_mask_pkg::IDX_STATUS_LOW);
  assign rd_status_high = reg_hit(REG_RD_I, REG_SEL_I,
                                  irq_mask_pkg::IDX_STATUS_HIGH);
  assign wr_mask = reg_hit(REG_WR_I, REG_SEL_I,
                           irq_mask_pkg::IDX_SOURCE_MASK);
  assign wr_mode_low = reg_hit(REG_WR_I, REG_SEL_I,
                               irq_mask_pkg::IDX_MODE_LOW);
  assign wr_mode_high = reg_hit(REG_WR_I, REG_SEL_I,
                                irq_mask_pkg::IDX_MODE_HIGH);

  status_clear_seq u_clear (
    .clk_i (CLK_I),
    .rst_n_i (rst_n_r),
    .int_reg_read_i (INT_REG_READ_I),
    .status_low_read_i (rd_status_low),
    .status_high_read_i (rd_status_high),
    .clear_o (status_clear)
  );

  // The event-missed mask may only drop in a write that also unmasks event-ready
  always_comb begin
    mask_wr_val = REG_WDATA_I;
    if (REG_WDATA_I[irq_mask_pkg::POS_EVT_READY] &&
        source_mask_r[irq_mask_pkg::POS_EVT_MISSED]) begin
      mask_wr_val[irq_mask_pkg::POS_EVT_MISSED] = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      source_mask_r <= irq_mask_pkg::SOURCE_MASK_RESET;
    end else if (wr_mask) begin
      source_mask_r <= mask_wr_val;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_low_r <= irq_mask_pkg::MODE_RESET;
    end else if (wr_mode_low) begin
      mode_low_r <= REG_WDATA_I & irq_mask_pkg::MODE_LOW_WMASK;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_high_r <= irq_mask_pkg::MODE_RESET;
    end else if (wr_mode_high) begin
      mode_high_r <= REG_WDATA_I & irq_mask_pkg::MODE_HIGH_WMASK;
    end
  end

  // Detection is never gated by any mask; a new event beats the clear
  always_comb begin
    port_event_status_nxt = port_event_status_r;
    if (status_clear) begin
      port_event_status_nxt = 12'h000;
    end
    port_event_status_nxt = port_event_status_nxt | port_evt;
  end

  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      port_event_status_r <= 12'h000;
    end else begin
      port_event_status_r <= port_event_status_nxt;
    end
  end

  // An event on a port whose status is still pending is a missed event
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      evt_missed_r <= 1'b0;
    end else if (|(port_evt & port_event_status_r)) begin
      evt_missed_r <= 1'b1;
    end else if (status_clear) begin
      evt_missed_r <= 1'b0;
    end
  end

  // Flags leave registered so the interrupt register sees clean levels
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      INPUT_EVENT_READY_FLAG_O <= 1'b0;
    end else begin
      INPUT_EVENT_READY_FLAG_O <= |port_event_status_r;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      INPUT_EVENT_MISSED_FLAG_O <= 1'b0;
    end else begin
      INPUT_EVENT_MISSED_FLAG_O <= evt_missed_r;
    end
  end

  // Register reads answer one cycle after the strobe
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= REG_RD_I;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= 16'h0000;
    end else begin
      if (REG_RD_I) begin
        unique case (REG_SEL_I)
          irq_mask_pkg::IDX_SOURCE_MASK: rdata_r <= source_mask_r;
          irq_mask_pkg::IDX_MODE_LOW: rdata_r <= mode_low_r;
          irq_mask_pkg::IDX_MODE_HIGH: rdata_r <= mode_high_r;
          irq_mask_pkg::IDX_STATUS_LOW:
            rdata_r <= {port_event_status_r[10:6], 3'h0,
                        port_event_status_r[5:0], 2'h0};
          irq_mask_pkg::IDX_STATUS_HIGH:
            rdata_r <= {15'h0000, port_event_status_r[11]};
          default: rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  assign REG_RDATA_O = rdata_r;
  assign REG_RVALID_O = rvalid_r;

  // Continuous-sweep pulse runs on its own, independent of the flag
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pulse_cnt_r <= 4'h0;
    end else if (CONT_SWEEP_MODE_I && SWEEP_DONE_I &&
                 !source_mask_r[irq_mask_pkg::POS_SWEEP_END]) begin
      pulse_cnt_r <= irq_mask_pkg::PULSE_CNT_W'(
                       irq_mask_pkg::SWEEP_PULSE_CYCLES);
    end else if (pulse_cnt_r != 4'h0) begin
      pulse_cnt_r <= pulse_cnt_r - 4'h1;
    end
  end

  // Each source sits at its mask bit; a set mask bit blocks it
  always_comb begin
    pending = 16'h0000;
    pending[irq_mask_pkg::POS_SWEEP_END] = SWEEP_END_FLAG_I;
    pending[irq_mask_pkg::POS_CONV_READY] = CONVERSION_READY_FLAG_I;
    pending[irq_mask_pkg::POS_CONV_MISSED] =
      CONVERSION_MISSED_FLAG_I;
    pending[irq_mask_pkg::POS_EVT_READY] = |port_event_status_r;
    pending[irq_mask_pkg::POS_EVT_MISSED] = evt_missed_r;
    pending[irq_mask_pkg::POS_OVERCURRENT] =
      DRIVER_OVERCURRENT_FLAG_I;
    pending[irq_mask_pkg::POS_CORE_TEMP +: 3] =
      CORE_TEMP_ALARM_BITS_I;
    pending[irq_mask_pkg::POS_REMOTE_A +: 3] =
      REMOTE_TEMP_A_ALARM_BITS_I;
    pending[irq_mask_pkg::POS_REMOTE_B +: 3] =
      REMOTE_TEMP_B_ALARM_BITS_I;
    pending[irq_mask_pkg::POS_HV_SUPPLY] = HV_SUPPLY_ALARM_FLAG_I;
  end

  // Registered so the line cannot glitch; costs one cycle of latency
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      int_n_r <= 1'b1;
    end else begin
      int_n_r <= !(|(pending & ~source_mask_r) ||
                   pulse_cnt_r != 4'h0);
    end
  end

  assign INT_N_O = int_n_r;
endmodule
`default_nettype wire

// >>> bench/irq_mask_monitor.sv
`default_nettype none
module irq_mask_monitor (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Register writes
  input wire logic [2:0] REG_SEL_I,
  input wire logic REG_WR_I,
  input wire logic [15:0] REG_WDATA_I,
  // Sources and sweep timing
  input wire logic SWEEP_END_FLAG_I,
  input wire logic CONVERSION_READY_FLAG_I,
  input wire logic CONVERSION_MISSED_FLAG_I,
  input wire logic DRIVER_OVERCURRENT_FLAG_I,
  input wire logic [2:0] CORE_TEMP_ALARM_BITS_I,
  input wire logic [2:0] REMOTE_TEMP_A_ALARM_BITS_I,
  input wire logic [2:0] REMOTE_TEMP_B_ALARM_BITS_I,
  input wire logic HV_SUPPLY_ALARM_FLAG_I,
  input wire logic CONT_SWEEP_MODE_I,
  input wire logic SWEEP_DONE_I,
  // Design outputs
  input wire logic INPUT_EVENT_READY_FLAG_O,
  input wire logic INPUT_EVENT_MISSED_FLAG_O,
  input wire logic INT_N_O
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] m_r;
  // Shadow mask; a write holding bit 3 cannot clear bit 4
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      m_r <= irq_mask_pkg::SOURCE_MASK_RESET;
    end else if (REG_WR_I && REG_SEL_I == irq_mask_pkg::IDX_SOURCE_MASK) begin
      m_r <= REG_WDATA_I;
      m_r[4] <= REG_WDATA_I[4] | (REG_WDATA_I[3] & m_r[4]);
    end
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  sequence sweep_go;
    SWEEP_DONE_I && CONT_SWEEP_MODE_I && !m_r[0];
  endsequence
  sequence low_ten;
    (!INT_N_O) [*8] ##1 (!INT_N_O) [*2];
  endsequence
  sweep_pulse_a: assert property (sweep_go |=> ##1 low_ten)
    else $error("sweep pulse too short");
  sweep_flag_a: assert property (
    SWEEP_END_FLAG_I && !m_r[0] |=> !INT_N_O) else $error("sweep flag lost");
  conv_ready_a: assert property (
    CONVERSION_READY_FLAG_I && !m_r[1] |=> !INT_N_O) else $error("ready lost");
  conv_missed_a: assert property (
    CONVERSION_MISSED_FLAG_I && !m_r[2] |=> !INT_N_O) else $error("miss lost");
  evt_ready_a: assert property (
    INPUT_EVENT_READY_FLAG_O && !m_r[3] |-> ##[0:1] !INT_N_O)
    else $error("event lost");
  evt_missed_a: assert property (
    INPUT_EVENT_MISSED_FLAG_O && !m_r[4] |-> ##[0:1] !INT_N_O)
    else $error("event miss lost");
  overcurrent_a: assert property (
    DRIVER_OVERCURRENT_FLAG_I && !m_r[5] |=> !INT_N_O) else $error("oc lost");
  core_temp_a: assert property (
    |(CORE_TEMP_ALARM_BITS_I & ~m_r[8:6]) |=> !INT_N_O) else $error("core");
  remote_a_a: assert property (
    |(REMOTE_TEMP_A_ALARM_BITS_I & ~m_r[11:9]) |=> !INT_N_O) else $error("ra");
  remote_b_a: assert property (
    |(REMOTE_TEMP_B_ALARM_BITS_I & ~m_r[14:12]) |=> !INT_N_O)
    else $error("rb");
  hv_supply_a: assert property (
    HV_SUPPLY_ALARM_FLAG_I && !m_r[15] |=> !INT_N_O) else $error("hv lost");
endmodule
bind irq_mask_top irq_mask_monitor chk (
  .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .REG_SEL_I(REG_SEL_I),
  .REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I),
  .SWEEP_END_FLAG_I(SWEEP_END_FLAG_I),
  .CONVERSION_READY_FLAG_I(CONVERSION_READY_FLAG_I),
  .CONVERSION_MISSED_FLAG_I(CONVERSION_MISSED_FLAG_I),
  .DRIVER_OVERCURRENT_FLAG_I(DRIVER_OVERCURRENT_FLAG_I),
  .CORE_TEMP_ALARM_BITS_I(CORE_TEMP_ALARM_BITS_I),
  .REMOTE_TEMP_A_ALARM_BITS_I(REMOTE_TEMP_A_ALARM_BITS_I),
  .REMOTE_TEMP_B_ALARM_BITS_I(REMOTE_TEMP_B_ALARM_BITS_I),
  .HV_SUPPLY_ALARM_FLAG_I(HV_SUPPLY_ALARM_FLAG_I),
  .CONT_SWEEP_MODE_I(CONT_SWEEP_MODE_I), .SWEEP_DONE_I(SWEEP_DONE_I),
  .INPUT_EVENT_READY_FLAG_O(INPUT_EVENT_READY_FLAG_O),
  .INPUT_EVENT_MISSED_FLAG_O(INPUT_EVENT_MISSED_FLAG_O),
  .INT_N_O(INT_N_O)
);
`default_nettype wire

// >>> bench/host_model.sv
`default_nettype none
module host_model (
  // Clock and answers
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic [15:0] rdata_i,
  // Requests
  output logic [2:0] sel_o,
  output logic wr_o,
  output logic rd_o,
  output logic [15:0] wdata_o,
  output logic irq_read_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int timeouts = 0;
  initial begin
    sel_o = 3'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
    irq_read_o = 1'b0;
  end
  task automatic wr(input logic [2:0] idx, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    sel_o = idx;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    // Stale data must not look valid
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [2:0] idx, output logic [15:0] d);
    int i;
    @(posedge clk_i);
    #1;
    sel_o = idx;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = 16'hXXXX;
    for (i = 0; i < 4; i++) begin
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        break;
      end
      @(posedge clk_i);
      #1;
    end
    if (rvalid_i !== 1'b1) timeouts++;
  endtask
  task automatic ack();
    logic [15:0] d;
    @(posedge clk_i);
    #1;
    irq_read_o = 1'b1;
    @(posedge clk_i);
    #1;
    irq_read_o = 1'b0;
    rd(irq_mask_pkg::IDX_STATUS_LOW, d);
    rd(irq_mask_pkg::IDX_STATUS_HIGH, d);
  endtask
endmodule
`default_nettype wire

// >>> bench/irq_mask_top_test.sv
`default_nettype none
module irq_mask_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] sel;
  logic wr, rd, irq_rd, rvalid, ev_rdy, ev_mis, int_n;
  logic cont = 1'b0;
  logic done = 1'b0;
  logic [15:0] wd, rdata, d;
  logic [15:0] src = 16'h0000;
  logic [11:0] pins = 12'h000;
  logic [11:0] st = 12'h000;
  logic mis = 1'b0;
  logic [31:0] seed = 32'h0000C045;
  logic [31:0] mr;
  int n_errors = 0;
  int total_checks = 0;
  int p, code, b, n;
  always #5 clk = ~clk;
  irq_mask_top uut (
    .CLK_I(clk), .ARST_N_I(arst_n), .REG_SEL_I(sel), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wd), .INT_REG_READ_I(irq_rd),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .SWEEP_END_FLAG_I(src[0]), .CONVERSION_READY_FLAG_I(src[1]),
    .CONVERSION_MISSED_FLAG_I(src[2]), .DRIVER_OVERCURRENT_FLAG_I(src[5]),
    .CORE_TEMP_ALARM_BITS_I(src[8:6]),
    .REMOTE_TEMP_A_ALARM_BITS_I(src[11:9]),
    .REMOTE_TEMP_B_ALARM_BITS_I(src[14:12]),
    .HV_SUPPLY_ALARM_FLAG_I(src[15]), .CONT_SWEEP_MODE_I(cont),
    .SWEEP_DONE_I(done), .PORT_LEVEL_I(pins),
    .INPUT_EVENT_READY_FLAG_O(ev_rdy), .INPUT_EVENT_MISSED_FLAG_O(ev_mis),
    .INT_N_O(int_n)
  );
  host_model host (
    .clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .sel_o(sel),
    .wr_o(wr), .rd_o(rd), .wdata_o(wd), .irq_read_o(irq_rd)
  );
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic rdchk(input logic [2:0] idx, input logic [15:0] exp);
    host.rd(idx, d);
    if (host.timeouts != 0) begin
      n_errors++;
      wrap_up();
    end else begin
      chk16(d, exp);
    end
  endtask
  task automatic stchk();
    rdchk(irq_mask_pkg::IDX_STATUS_LOW,
          {st[10:6], 3'h0, st[5:0], 2'h0});
    rdchk(irq_mask_pkg::IDX_STATUS_HIGH, {15'h0000, st[11]});
    chk1(ev_rdy, |st);
    chk1(ev_mis, mis);
  endtask
  task automatic setpin(input logic v);
    if ((code == 1 && v && !pins[p]) || (code == 2 && !v && pins[p]) ||
        (code == 3 && v != pins[p])) begin
      mis = mis | st[p];
      st[p] = 1'b1;
    end
    pins[p] = v;
    // Three sync stages plus edge logic need a few cycles
    cyc(8);
  endtask
  task automatic clear_all();
    host.ack();
    st = 12'h000;
    mis = 1'b0;
    cyc(3);
  endtask
  task automatic setmode();
    mr = 32'h0;
    if (p < 6) mr[4 + 2 * p +: 2] = code[1:0];
    else if (p < 11) mr[22 + 2 * (p - 6) +: 2] = code[1:0];
    else mr[17:16] = code[1:0];
    host.wr(irq_mask_pkg::IDX_MODE_LOW, mr[15:0]);
    host.wr(irq_mask_pkg::IDX_MODE_HIGH, mr[31:16]);
    rdchk(irq_mask_pkg::IDX_MODE_LOW, mr[15:0]);
    rdchk(irq_mask_pkg::IDX_MODE_HIGH, mr[31:16]);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    arst_n = 1'b1;
    cyc(3);
    rdchk(irq_mask_pkg::IDX_SOURCE_MASK, irq_mask_pkg::SOURCE_MASK_RESET);
    rdchk(irq_mask_pkg::IDX_MODE_LOW, irq_mask_pkg::MODE_RESET);
    rdchk(irq_mask_pkg::IDX_MODE_HIGH, irq_mask_pkg::MODE_RESET);
    host.wr(3'h5, 16'hFFFF);
    rdchk(3'h5, 16'h0000);
    repeat (2) begin
      mr = rnd();
      host.wr(irq_mask_pkg::IDX_MODE_LOW, mr[15:0]);
      host.wr(irq_mask_pkg::IDX_MODE_HIGH, mr[31:16]);
      rdchk(irq_mask_pkg::IDX_MODE_LOW, mr[15:0] & 16'hFFF0);
      rdchk(irq_mask_pkg::IDX_MODE_HIGH, mr[31:16] & 16'hFFC3);
    end
    for (b = 0; b < 16; b++) begin
      if (b == 3 || b == 4) continue;
      host.wr(irq_mask_pkg::IDX_SOURCE_MASK, ~(16'h0001 << b));
      src = 16'h0001 << b;
      cyc(2);
      chk1(int_n, 1'b0);
      // Every other source except event-ready and event-missed active but masked
      src = 16'hFFE7 & ~(16'h0001 << b);
      cyc(2);
      chk1(int_n, 1'b1);
      src = 16'h0000;
    end
    host.wr(irq_mask_pkg::IDX_SOURCE_MASK, 16'hFFEF);
    rdchk(irq_mask_pkg::IDX_SOURCE_MASK, 16'hFFFF);
    host.wr(irq_mask_pkg::IDX_SOURCE_MASK, 16'hFFE7);
    rdchk(irq_mask_pkg::IDX_SOURCE_MASK, 16'hFFE7);
    host.wr(irq_mask_pkg::IDX_SOURCE_MASK, 16'hFFFF);
    mr = rnd();
    p = mr % 12;
    for (code = 0; code < 4; code++) begin
      setmode();
      mr = rnd();
      pins = mr[11:0] & ~(12'h001 << p);
      cyc(8);
      setpin(1'b1);
      stchk();
      setpin(1'b0);
      stchk();
      chk1(int_n, 1'b1);
      clear_all();
      stchk();
    end
    code = 3;
    host.wr(irq_mask_pkg::IDX_SOURCE_MASK, 16'hFFF7);
    setpin(1'b1);
    chk1(int_n, 1'b0);
    setpin(1'b0);
    stchk();
    host.wr(irq_mask_pkg::IDX_SOURCE_MASK, 16'hFFFF);
    cyc(2);
    chk1(int_n, 1'b1);
    host.wr(irq_mask_pkg::IDX_SOURCE_MASK, 16'hFFE7);
    cyc(2);
    chk1(int_n, 1'b0);
    clear_all();
    chk1(int_n, 1'b1);
    stchk();
    host.wr(irq_mask_pkg::IDX_SOURCE_MASK, 16'hFFFE);
    for (b = 0; b < 2; b++) begin
      cont = (b == 0);
      cyc(1);
      done = 1'b1;
      cyc(1);
      done = 1'b0;
      n = 0;
      repeat (14) begin
        cyc(1);
        if (int_n === 1'b0) n++;
      end
      d = (b == 0) ? 16'(irq_mask_pkg::SWEEP_PULSE_CYCLES) : 16'h0000;
      chk16(n[15:0], d);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
